// ==== hw/qu_pkg.sv ====
// Purpose: Shared constants and types for the quad serial channel block
// Assumes: 200 MHz system clock, synchronous active-high reset
// Notes: Control bits arrive as plain ports, no register bus
package qu_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;
    localparam int CLK_HZ = 200_000_000;
    localparam int MAX_BAUD_HZ = 1_500_000;
    // Sixteen oversample ticks per bit
    localparam int OVS = 16;
    localparam int OVS_DIV_MIN = CLK_HZ / (MAX_BAUD_HZ * OVS);
    localparam logic [15:0] DIV_RST = 16'h0008;
    // Modem control field positions
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_INTEN_BIT = 3;
    localparam int MCR_LOOP_BIT = 4;
    // Modem status field positions
    localparam int MSR_CTS_BIT = 4;
    localparam int MSR_DSR_BIT = 5;
    localparam int MSR_RI_BIT = 6;
    localparam int MSR_CD_BIT = 7;
    localparam int MSR_DRI_BIT = 2;
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_C = 2'h2;
    localparam logic [1:0] SEL_D = 2'h3;
    localparam logic [3:0] OVS_LAST = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    localparam logic [3:0] BITS_DATA = 4'h8;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic perr;
    } qu_rx_word_t;

    typedef struct packed {
        logic parity_en;
        logic parity_odd;
        logic two_stop;
        logic tx_enable;
    } qu_line_cfg_t;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } qu_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } qu_rx_state_t;

    function automatic logic par_of(input logic [DATA_W-1:0] d, input logic odd);
        par_of = (^d) ^ odd;
    endfunction
endpackage

// ==== hw/qu_fifo.sv ====
// Purpose: Flip-flop FIFO with valid and ready on both sides
// Assumes: One clock, synchronous reset
// Notes: Used for 16-byte queues and the two-entry output buffer
`timescale 1ns/1ps
module qu_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [AW:0] count
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    always_comb
    begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push)
        begin
            nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
        end
        if (pop)
        begin
            nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop)
        begin
            nxt_cnt = cnt_ff + 1'b1;
        end
        else if (pop && !push)
        begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
        if (push)
        begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];
    assign count = cnt_ff;
endmodule

// ==== hw/qu_channel.sv ====
// Purpose: One serial channel: framing, FIFOs, modem lines, bus selection
// Assumes: Inputs synchronous to clock; divisor gives the 16x tick rate
// Notes: One instance per channel; CH picks its select and address
`timescale 1ns/1ps
module qu_channel
    import qu_pkg::*;
#(
    parameter int CH = 0
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic bus_mode_individual,
    input wire logic [NUM_CH-1:0] chip_select_n,
    input wire logic shared_chip_select_n,
    input wire logic [1:0] channel_address_bits,
    input wire logic interrupt_mode_select_pin,
    input wire logic [15:0] baud_divisor,
    input wire qu_line_cfg_t line_cfg,
    input wire logic [7:0] modem_control_register,
    input wire logic [DATA_W-1:0] tx_wdata,
    input wire logic tx_wvalid,
    output logic tx_wready,
    output qu_rx_word_t rx_rdata,
    output logic rx_rvalid,
    input wire logic rx_rready,
    input wire logic msr_read,
    output logic [7:0] modem_status_register,
    input wire logic serial_in,
    input wire logic ring_indicator_n,
    input wire logic clear_to_send_n,
    input wire logic data_set_ready_n,
    input wire logic carrier_detect_n,
    output logic serial_out,
    output logic request_to_send_n,
    output logic data_terminal_ready_n,
    output logic irq_out,
    output logic irq_oe,
    output logic selected
);
    logic [15:0] div_ff, nxt_div;
    logic tick;
    qu_tx_state_t tx_st_ff, nxt_tx_st;
    logic [3:0] tx_ovs_ff, nxt_tx_ovs, tx_bit_ff, nxt_tx_bit;
    logic [DATA_W:0] tx_sh_ff, nxt_tx_sh;
    logic tx_out_ff, nxt_tx_out;
    qu_rx_state_t rx_st_ff, nxt_rx_st;
    logic [3:0] rx_ovs_ff, nxt_rx_ovs, rx_bit_ff, nxt_rx_bit;
    logic [DATA_W:0] rx_sh_ff, nxt_rx_sh;
    logic ri_ff, nxt_ri, dri_ff, nxt_dri;
    logic rts_ff, dtr_ff, irq_ff, oe_ff, sel_ff;
    logic nxt_sel;
    logic [7:0] msr_ff, nxt_msr;
    logic [DATA_W-1:0] txq_data;
    logic txq_valid, txq_ready;
    qu_rx_word_t rxw, rxq_data;
    logic rxw_valid, rxq_valid, rxq_ready;
    logic rx_line, tx_rdy_for_bit;
    logic [4:0] txq_cnt, rxq_cnt;

    // Tx queue: sixteen bytes
    qu_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txq (
        .clock(clock), .srst(srst),
        .in_data(tx_wdata), .in_valid(tx_wvalid), .in_ready(tx_wready),
        .out_data(txq_data), .out_valid(txq_valid), .out_ready(txq_ready),
        .count(txq_cnt)
    );
    // Rx queue: sixteen bytes plus error flag
    qu_fifo #(.WIDTH(DATA_W+1), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxq (
        .clock(clock), .srst(srst),
        .in_data(rxw), .in_valid(rxw_valid), .in_ready(),
        .out_data(rxq_data), .out_valid(rxq_valid), .out_ready(rxq_ready),
        .count(rxq_cnt)
    );
    // Two-entry buffer towards the reader
    qu_fifo #(.WIDTH(DATA_W+1), .DEPTH(2), .AW(1)) u_obuf (
        .clock(clock), .srst(srst),
        .in_data(rxq_data), .in_valid(rxq_valid), .in_ready(rxq_ready),
        .out_data(rx_rdata), .out_valid(rx_rvalid), .out_ready(rx_rready),
        .count()
    );

    // Oversample tick divider
    always_comb
    begin
        tick = (div_ff == 16'h0001) || (baud_divisor <= 16'h0001);
        nxt_div = (tick || div_ff == '0) ? baud_divisor : div_ff - 1'b1;
    end

    // Loopback: pin ignored, own output feeds receiver
    assign rx_line = modem_control_register[MCR_LOOP_BIT] ? tx_out_ff : serial_in;
    assign tx_rdy_for_bit = tick && (tx_ovs_ff == OVS_LAST);

    // Transmitter, no modem line in its path
    always_comb
    begin
        nxt_tx_st = tx_st_ff;
        nxt_tx_ovs = tick ? tx_ovs_ff + 1'b1 : tx_ovs_ff;
        nxt_tx_bit = tx_bit_ff;
        nxt_tx_sh = tx_sh_ff;
        nxt_tx_out = tx_out_ff;
        txq_ready = 1'b0;
        case (tx_st_ff)
            TX_IDLE:
            begin
                nxt_tx_out = 1'b1;
                nxt_tx_ovs = '0;
                if (txq_valid && line_cfg.tx_enable)
                begin
                    txq_ready = 1'b1;
                    nxt_tx_sh = {par_of(txq_data, line_cfg.parity_odd), txq_data};
                    nxt_tx_out = 1'b0;
                    nxt_tx_st = TX_START;
                end
            end
            TX_START:
            begin
                if (tx_rdy_for_bit)
                begin
                    nxt_tx_out = tx_sh_ff[0];
                    nxt_tx_sh = {1'b1, tx_sh_ff[DATA_W:1]};
                    nxt_tx_bit = '0;
                    nxt_tx_st = TX_DATA;
                end
            end
            TX_DATA:
            begin
                if (tx_rdy_for_bit)
                begin
                    nxt_tx_bit = tx_bit_ff + 1'b1;
                    nxt_tx_out = tx_sh_ff[0];
                    nxt_tx_sh = {1'b1, tx_sh_ff[DATA_W:1]};
                    // Parity bit sits after data when enabled
                    if (tx_bit_ff == BITS_DATA - 1'b1 && !line_cfg.parity_en)
                    begin
                        nxt_tx_out = 1'b1;
                        nxt_tx_bit = '0;
                        nxt_tx_st = TX_STOP;
                    end
                    else if (tx_bit_ff == BITS_DATA)
                    begin
                        nxt_tx_out = 1'b1;
                        nxt_tx_bit = '0;
                        nxt_tx_st = TX_STOP;
                    end
                end
            end
            TX_STOP:
            begin
                nxt_tx_out = 1'b1;
                if (tx_rdy_for_bit)
                begin
                    nxt_tx_bit = tx_bit_ff + 1'b1;
                    if (tx_bit_ff == {3'h0, line_cfg.two_stop})
                    begin
                        nxt_tx_st = TX_IDLE;
                    end
                end
            end
            default:
            begin
                nxt_tx_st = TX_IDLE;
            end
        endcase
    end

    // Receiver, sampling at mid-bit
    always_comb
    begin
        nxt_rx_st = rx_st_ff;
        nxt_rx_ovs = tick ? rx_ovs_ff + 1'b1 : rx_ovs_ff;
        nxt_rx_bit = rx_bit_ff;
        nxt_rx_sh = rx_sh_ff;
        rxw = '{data: rx_sh_ff[DATA_W-1:0], perr: 1'b0};
        rxw_valid = 1'b0;
        case (rx_st_ff)
            RX_IDLE:
            begin
                nxt_rx_ovs = '0;
                if (!rx_line)
                begin
                    nxt_rx_st = RX_START;
                end
            end
            RX_START:
            begin
                if (tick && rx_ovs_ff == OVS_MID)
                begin
                    nxt_rx_ovs = '0;
                    nxt_rx_bit = '0;
                    nxt_rx_st = rx_line ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA:
            begin
                if (tick && rx_ovs_ff == OVS_LAST)
                begin
                    nxt_rx_sh = {rx_line, rx_sh_ff[DATA_W:1]};
                    nxt_rx_bit = rx_bit_ff + 1'b1;
                    if ((rx_bit_ff == BITS_DATA - 1'b1 && !line_cfg.parity_en)
                        || rx_bit_ff == BITS_DATA)
                    begin
                        nxt_rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP:
            begin
                if (tick && rx_ovs_ff == OVS_LAST)
                begin
                    nxt_rx_st = RX_IDLE;
                    rxw_valid = 1'b1;
                    if (line_cfg.parity_en)
                    begin
                        rxw.data = rx_sh_ff[DATA_W-1:0];
                        rxw.perr = par_of(rx_sh_ff[DATA_W-1:0], line_cfg.parity_odd)
                            != rx_sh_ff[DATA_W];
                    end
                    else
                    begin
                        rxw.data = rx_sh_ff[DATA_W:1];
                    end
                end
            end
            default:
            begin
                nxt_rx_st = RX_IDLE;
            end
        endcase
    end

    // Modem status and selection
    always_comb
    begin
        nxt_ri = ring_indicator_n;
        // Set wins over clear by read
        nxt_dri = (!ri_ff && ring_indicator_n) || (dri_ff && !msr_read);
        nxt_msr = '0;
        nxt_msr[MSR_CTS_BIT] = !clear_to_send_n;
        nxt_msr[MSR_DSR_BIT] = !data_set_ready_n;
        nxt_msr[MSR_RI_BIT] = !ring_indicator_n;
        nxt_msr[MSR_CD_BIT] = !carrier_detect_n;
        nxt_msr[MSR_DRI_BIT] = nxt_dri;
        if (bus_mode_individual)
        begin
            nxt_sel = !chip_select_n[CH];
        end
        else
        begin
            nxt_sel = !shared_chip_select_n
                && (channel_address_bits == 2'(CH));
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            div_ff <= DIV_RST;
            tx_st_ff <= TX_IDLE;
            tx_ovs_ff <= '0;
            tx_bit_ff <= '0;
            tx_sh_ff <= '0;
            tx_out_ff <= 1'b1;
            rx_st_ff <= RX_IDLE;
            rx_ovs_ff <= '0;
            rx_bit_ff <= '0;
            rx_sh_ff <= '0;
            ri_ff <= 1'b1;
            dri_ff <= 1'b0;
            msr_ff <= '0;
            rts_ff <= 1'b1;
            dtr_ff <= 1'b1;
            irq_ff <= 1'b0;
            oe_ff <= 1'b0;
            sel_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            tx_st_ff <= nxt_tx_st;
            tx_ovs_ff <= nxt_tx_ovs;
            tx_bit_ff <= nxt_tx_bit;
            tx_sh_ff <= nxt_tx_sh;
            tx_out_ff <= line_cfg.tx_enable ? nxt_tx_out : 1'b1;
            rx_st_ff <= nxt_rx_st;
            rx_ovs_ff <= nxt_rx_ovs;
            rx_bit_ff <= nxt_rx_bit;
            rx_sh_ff <= nxt_rx_sh;
            ri_ff <= nxt_ri;
            dri_ff <= nxt_dri;
            msr_ff <= nxt_msr;
            rts_ff <= !modem_control_register[MCR_RTS_BIT];
            dtr_ff <= !modem_control_register[MCR_DTR_BIT];
            irq_ff <= nxt_dri || rxq_valid;
            // Shared mode or pin high keeps enable on; individual mode with pin low lets bit 3 gate it
            oe_ff <= !bus_mode_individual || interrupt_mode_select_pin
                || modem_control_register[MCR_INTEN_BIT];
            sel_ff <= nxt_sel;
        end
    end

    assign serial_out = tx_out_ff;
    assign request_to_send_n = rts_ff;
    assign data_terminal_ready_n = dtr_ff;
    assign modem_status_register = msr_ff;
    assign irq_out = irq_ff;
    assign irq_oe = oe_ff;
    assign selected = sel_ff;
endmodule

// ==== verif/qu_channel_checker.sv ====
// Purpose: Port assertions for one serial channel
// Assumes: One clock, srst synchronous active high
// Notes: Bound to every qu_channel instance
`timescale 1ns/1ps
module qu_channel_checker #(
    parameter int CH = 0
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic bus_mode_individual,
    input wire logic [qu_pkg::NUM_CH-1:0] chip_select_n,
    input wire logic shared_chip_select_n,
    input wire logic [1:0] channel_address_bits,
    input wire logic interrupt_mode_select_pin,
    input wire qu_pkg::qu_line_cfg_t line_cfg,
    input wire logic [7:0] modem_control_register,
    input wire logic ring_indicator_n,
    input wire logic clear_to_send_n,
    input wire logic [7:0] modem_status_register,
    input wire logic serial_out,
    input wire logic request_to_send_n,
    input wire logic data_terminal_ready_n,
    input wire logic irq_oe,
    input wire logic selected
);
    import qu_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    chk_reset_idle:
        assert property (disable iff (1'b0) srst |=>
            request_to_send_n && serial_out && data_terminal_ready_n) else $error("reset level");
    chk_rts_drive:
        assert property (##1 request_to_send_n == !$past(modem_control_register[MCR_RTS_BIT]))
        else $error("rts level");
    chk_dtr_drive:
        assert property (##1 data_terminal_ready_n == !$past(modem_control_register[MCR_DTR_BIT]))
        else $error("dtr level");
    chk_tx_disabled:
        assert property (!line_cfg.tx_enable |=> serial_out) else $error("tx not idle");
    chk_start_bit:
        assert property ($fell(serial_out) |-> !serial_out [*8]) else $error("short start");
    chk_ring_flag:
        assert property ($rose(ring_indicator_n) |-> ##[1:4] modem_status_register[MSR_DRI_BIT])
        else $error("ring flag");
    chk_cts_status:
        assert property (##1 modem_status_register[MSR_CTS_BIT] == !$past(clear_to_send_n))
        else $error("cts status");
    chk_sel_individual:
        assert property (bus_mode_individual |=> selected == !$past(chip_select_n[CH]))
        else $error("select individual");
    chk_sel_shared:
        assert property (!bus_mode_individual |=> selected == (!$past(shared_chip_select_n)
            && $past(channel_address_bits) == 2'(CH))) else $error("select shared");
    chk_irq_gate:
        assert property (bus_mode_individual |=> irq_oe == ($past(interrupt_mode_select_pin)
            || $past(modem_control_register[MCR_INTEN_BIT]))) else $error("irq enable");
    cov_ring: cover property ($rose(modem_status_register[MSR_DRI_BIT]));
    cov_shared: cover property (!bus_mode_individual && selected);
    cov_start: cover property ($fell(serial_out));
endmodule

bind qu_channel qu_channel_checker #(.CH(CH)) qu_channel_checker_inst (.*);

// ==== verif/qu_far_end.sv ====
// Purpose: Far end of the serial line: sends and collects frames
// Assumes: Parity on, BIT_CLK clocks per bit
// Notes: jam puts noise on the line to show it is ignored
`timescale 1ns/1ps
module qu_far_end #(
    parameter int BIT_CLK = 16
) (
    input wire logic clock,
    input wire logic serial_out,
    input wire logic jam,
    output logic serial_in
);
    logic line_lvl = 1'b1;
    logic noise = 1'b0;
    logic [9:0] seen[$];
    assign serial_in = jam ? noise : line_lvl;
    always @(posedge clock)
        noise <= ~noise;
    task automatic send(input logic [7:0] d, input logic odd, input logic bad);
        logic [11:0] f;
        f = {2'b11, ^d ^ odd ^ bad, d, 1'b0};
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clock);
            line_lvl <= f[i];
            repeat (BIT_CLK - 1) @(posedge clock);
        end
    endtask
    // Collects stop, parity and data of each frame
    always
    begin
        logic [9:0] w;
        @(negedge serial_out);
        repeat (BIT_CLK / 2) @(posedge clock);
        for (int j = 0; j < 10; j++)
        begin
            repeat (BIT_CLK) @(posedge clock);
            w[j] = serial_out;
        end
        seen.push_back(w);
    end
endmodule

// ==== verif/qu_channel_tb.sv ====
// Purpose: Self-checking bench for one serial channel
// Assumes: Divisor 1, so one bit is 16 clocks; the loopback test uses divisor 2
// Notes: Channel D instance, far end in qu_far_end
`timescale 1ns/1ps
module qu_channel_tb;
    import qu_pkg::*;
    localparam int CH = 3;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic bus_mode_individual = 1'b1;
    logic [3:0] chip_select_n = 4'hf;
    logic shared_chip_select_n = 1'b1;
    logic [1:0] channel_address_bits = 2'h0;
    logic interrupt_mode_select_pin = 1'b0;
    logic [15:0] baud_divisor = 16'h0001;
    qu_line_cfg_t line_cfg = '0;
    logic [7:0] modem_control_register = 8'h00;
    logic [7:0] tx_wdata = 8'h00;
    logic tx_wvalid = 1'b0;
    logic rx_rready = 1'b0;
    logic msr_read = 1'b0;
    logic ring_indicator_n = 1'b1;
    logic clear_to_send_n = 1'b1;
    logic data_set_ready_n = 1'b1;
    logic carrier_detect_n = 1'b1;
    logic jam = 1'b0;
    logic tx_wready, rx_rvalid, serial_in, serial_out, request_to_send_n;
    logic data_terminal_ready_n, irq_out, irq_oe, selected;
    logic [7:0] modem_status_register;
    qu_rx_word_t rx_rdata;
    int fail_count = 0;
    int n_compared = 0;
    logic [15:0] lfsr = 16'hba22;
    logic odd = 1'b0;
    logic [9:0] txq[$];
    logic [8:0] rxq[$];

    qu_channel #(.CH(CH)) qu_channel_inst (.*);
    qu_far_end #(.BIT_CLK(16)) qu_far_end_inst (.*);

    always #2.5 clock = ~clock;

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    task automatic cmp_word(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({9'h0, got}, {9'h0, exp});
    endtask

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic send_tx(input int lim, output int n);
        n = 0;
        @(posedge clock);
        tx_wdata <= rnd();
        tx_wvalid <= 1'b1;
        @(negedge clock);
        while (tx_wready === 1'b1 && n < lim)
        begin
            @(posedge clock);
            txq.push_back({1'b1, ^tx_wdata ^ odd, tx_wdata});
            n++;
            tx_wdata <= rnd();
            if (n == lim)
                tx_wvalid <= 1'b0;
            @(negedge clock);
        end
        @(posedge clock);
        tx_wvalid <= 1'b0;
    endtask

    task automatic drain();
        int t = 0;
        @(posedge clock);
        rx_rready <= 1'b1;
        while (rxq.size() > 0 && t < 4000)
        begin
            @(negedge clock);
            t++;
            if (rx_rvalid === 1'b1)
                cmp_word(10'(rx_rdata), 10'(rxq.pop_front()));
        end
        cmp_word(10'(rxq.size()), 10'h000);
        @(posedge clock);
        rx_rready <= 1'b0;
    endtask

    initial
    begin
        int n;
        logic [7:0] d;
        logic [9:0] w;
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        cmp_bit(serial_out, 1'b1);
        cmp_bit(request_to_send_n, 1'b1);
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            modem_control_register <= 8'(i);
            clear_to_send_n <= rnd() < 8'h80;
            settle(2);
            cmp_bit(request_to_send_n, !i[1]);
            cmp_bit(data_terminal_ready_n, !i[0]);
            cmp_bit(modem_status_register[MSR_CTS_BIT], !clear_to_send_n);
        end
        $display("test modem lines done");
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clock);
            chip_select_n <= ~(4'h1 << i);
            settle(1);
            cmp_bit(selected, i == CH);
        end
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock);
            bus_mode_individual <= 1'b0;
            {shared_chip_select_n, channel_address_bits} <= 3'(i);
            chip_select_n <= 4'(rnd());
            settle(1);
            cmp_bit(selected, i == CH);
        end
        $display("test select done");
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            bus_mode_individual <= 1'b1;
            interrupt_mode_select_pin <= i[1];
            modem_control_register <= {4'h0, i[0], 3'h0};
            settle(1);
            cmp_bit(irq_oe, i != 0);
        end
        $display("test irq enable done");
        @(posedge clock);
        ring_indicator_n <= 1'b0;
        settle(4);
        cmp_bit(modem_status_register[MSR_DRI_BIT], 1'b0);
        @(posedge clock);
        ring_indicator_n <= 1'b1;
        settle(4);
        cmp_bit(modem_status_register[MSR_DRI_BIT], 1'b1);
        cmp_bit(irq_out, 1'b1);
        @(posedge clock);
        msr_read <= 1'b1;
        @(posedge clock);
        msr_read <= 1'b0;
        settle(2);
        cmp_bit(modem_status_register[MSR_DRI_BIT], 1'b0);
        $display("test ring done");
        odd = lfsr[0];
        @(posedge clock);
        line_cfg <= '{1'b1, odd, 1'b0, 1'b0};
        send_tx(20, n);
        cmp_word(10'(n), 10'h010);
        cmp_bit(serial_out, 1'b1);
        @(posedge clock);
        line_cfg.tx_enable <= 1'b1;
        modem_control_register <= 8'h02;
        n = 0;
        while (qu_far_end_inst.seen.size() < txq.size() && n < 6000)
        begin
            @(posedge clock);
            n++;
        end
        cmp_word(10'(qu_far_end_inst.seen.size()), 10'(txq.size()));
        while (txq.size() > 0 && qu_far_end_inst.seen.size() > 0)
            cmp_word(qu_far_end_inst.seen.pop_front(), txq.pop_front());
        settle(20);
        cmp_bit(serial_out, 1'b1);
        $display("test transmit done");
        for (int i = 0; i < 4; i++)
        begin
            d = rnd();
            qu_far_end_inst.send(d, odd, i == 2);
            rxq.push_back({d, i == 2});
        end
        drain();
        $display("test receive done");
        @(posedge clock);
        modem_control_register <= 8'h10;
        line_cfg <= '{1'b0, odd, 1'b1, 1'b1};
        baud_divisor <= 16'h0002;
        jam <= 1'b1;
        send_tx(2, n);
        cmp_word(10'(n), 10'h002);
        while (txq.size() > 0)
        begin
            w = txq.pop_front();
            rxq.push_back({w[7:0], 1'b0});
        end
        drain();
        $display("test loopback done");
        conclude();
    end

    initial
    begin
        repeat (40000) @(posedge clock);
        fail_count++;
        conclude();
    end
endmodule
